// *** dv/fc_partner.sv ***
`default_nettype none
// ****
// remote serializer, forward channel side
// ****
module fc_partner (
   // clock
   input  wire logic       clk,
   // configuration strobe and byte
   output var  logic       fc_cfg_valid,
   output var  logic [7:0] fc_cfg
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      fc_cfg_valid = 1'b0;
      fc_cfg       = 8'h00;
   end
   // one-cycle load; byte inverted after so stale data never looks valid
   task automatic send(logic [7:0] v);
      @(negedge clk);
      fc_cfg       = v;
      fc_cfg_valid = 1'b1;
      @(negedge clk);
      fc_cfg_valid = 1'b0;
      fc_cfg       = ~v;
   endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`default_nettype none
// ****
// register bank bench
// ****
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ov = 1'b0, un = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, fc_cfg;
   logic [1:0] gp = 2'h0;
   logic       reg_rvalid, fc_cfg_valid, video_disabled_o, dual_link_o, pclk_from_test_clock_o;
   logic       general_pin_one_oe, ctl_channel_en_o;
   logic       ce = 1'b1, bclk = 1'b0, wclk = 1'b0, i2s_bclk_o, i2s_wclk_o, general_pin_zero_o;
   logic       general_pin_zero_oe, general_pin_one_o, sync_signals_present_o, hold_local_config_o;
   logic       aud_edge_rising_o;
   logic [3:0] adata = 4'h0, i2s_data_o;
   logic [1:0] gpio_func_in, rx_lane_en_o, le [4] = '{2'h1, 2'h3, 2'h1, 2'h2};
   cfg_pkg::lane_mode_t receive_lane_mode_o;
   logic [7:0] ra [5] = '{8'h28, 8'h2B, 8'h2E, 8'h34, 8'h40};
   int         fail_count = 0, cmp_count = 0;
   always #2 clk = ~clk;
   fc_partner P (.clk, .fc_cfg_valid, .fc_cfg);
   deser_datapath_audio_cfg DUT (.clk, .rst_b, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .reg_rvalid, .fc_cfg_valid, .fc_cfg, .aud_bclk(bclk), .aud_wclk(wclk), .aud_data(adata),
      .aud_overrun_evt(ov), .aud_underrun_evt(un), .i2s_bclk_o, .i2s_wclk_o, .i2s_data_o,
      .gpio_func_out(gp), .gpio_func_oe(gp), .gpio_func_in, .general_pin_zero_i(gp[0]),
      .general_pin_zero_o, .general_pin_zero_oe, .general_pin_one_i(gp[1]), .general_pin_one_o,
      .general_pin_one_oe, .video_disabled_o, .dual_link_o, .sync_signals_present_o,
      .hold_local_config_o, .ctl_channel_en_o, .aud_edge_rising_o, .pclk_from_test_clock_o,
      .receive_lane_mode_o, .rx_lane_en_o);
   task automatic chk(string n, logic [8:0] s, logic [8:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
   endtask
   // read answer lands one cycle after the strobe
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(negedge clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd   = 1'b0;
      chk("rdata", {reg_rvalid, reg_rdata}, {1'b1, e});
   endtask
   task automatic pulse(logic o, logic u);
      @(negedge clk);
      ov = o;
      un = u;
      @(negedge clk);
      ov = 1'b0;
      un = 1'b0;
   endtask
   // internal audio clocks and lanes, changed off the sampling edge
   task automatic aud(logic b, logic w, logic [3:0] d);
      @(negedge clk);
      bclk  = b;
      wclk  = w;
      adata = d;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // hang guard, far beyond the hundred or so cycles used
   initial begin
      #20000;
      fail_count++;
      final_report();
   end
   initial begin
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      foreach (ra[i]) rd(ra[i], 8'h00);
      wr(8'h2E, 8'h80);
      chk("pclk", pclk_from_test_clock_o, 9'h001);
      rd(8'h2E, 8'h80);
      // a write is not taken while the clock enable is low
      ce = 1'b0;
      wr(8'h2E, 8'h00);
      ce = 1'b1;
      chk("freeze", pclk_from_test_clock_o, 9'h001);
      P.send(8'h30);
      chk("vid", {dual_link_o, video_disabled_o}, 9'h003);
      wr(8'h28, 8'h80);
      rd(8'h28, 8'h90);
      chk("hold", hold_local_config_o, 9'h001);
      P.send(8'h2F);
      rd(8'h28, 8'h80);
      wr(8'h28, 8'h00);
      P.send(8'h23);
      rd(8'h28, 8'h23);
      chk("sync", {sync_signals_present_o, hold_local_config_o}, 9'h002);
      // pins keep their normal function while video is off
      gp = 2'b10;
      P.send(8'h20);
      @(negedge clk);
      chk("pin", {ctl_channel_en_o, general_pin_one_oe}, 9'h003);
      @(negedge clk);
      chk("pad", {gpio_func_in, general_pin_one_o, general_pin_zero_oe}, 9'h00A);
      gp = 2'b00;
      P.send(8'h08);
      @(negedge clk);
      chk("alt", general_pin_one_oe, 9'h001);
      P.send(8'h00);
      @(negedge clk);
      chk("alt", general_pin_one_oe, 9'h000);
      pulse(1'b1, 1'b0);
      rd(8'h2B, 8'h08);
      pulse(1'b0, 1'b1);
      rd(8'h2B, 8'h0C);
      wr(8'h2B, 8'h0F);
      pulse(1'b0, 1'b1);
      rd(8'h2B, 8'h03);
      wr(8'h2B, 8'h01);
      pulse(1'b0, 1'b1);
      rd(8'h2B, 8'h05);
      // strobe on rising: data launched on falling bit clock, all lanes
      P.send(8'h09);
      chk("edge", aud_edge_rising_o, 9'h001);
      aud(1'b1, 1'b1, 4'hB);
      aud(1'b0, 1'b1, 4'hB);
      aud(1'b0, 1'b0, 4'h4);
      chk("i2s", {i2s_bclk_o, i2s_wclk_o, i2s_data_o}, 9'h01B);
      @(negedge clk);
      chk("i2s hold", i2s_data_o, 9'h00B);
      chk("altpin", {general_pin_one_o, general_pin_zero_o, general_pin_one_oe, general_pin_zero_oe}, 9'h00F);
      P.send(8'h04);
      @(negedge clk);
      chk("i2s off", {i2s_bclk_o, i2s_wclk_o, i2s_data_o}, 9'h000);
      P.send(8'h00);
      aud(1'b1, 1'b1, 4'hF);
      aud(1'b0, 1'b1, 4'hF);
      @(negedge clk);
      chk("stereo", {i2s_wclk_o, i2s_data_o}, 9'h011);
      // strobe on falling: launch moves to the rising bit clock
      wr(8'h2B, 8'h00);
      aud(1'b1, 1'b0, 4'h0);
      @(negedge clk);
      chk("fall", {aud_edge_rising_o, i2s_wclk_o, i2s_data_o}, 9'h000);
      for (int m = 0; m < 4; m++) begin
         wr(8'h34, 8'(m << 3));
         @(negedge clk);
         chk("lane", {receive_lane_mode_o, rx_lane_en_o}, {5'h00, m[1:0], le[m]});
      end
      // auto mode follows the link width from the serializer
      wr(8'h34, 8'h00);
      P.send(8'h10);
      @(negedge clk);
      chk("auto", rx_lane_en_o, 9'h003);
      final_report();
   end
endmodule
`default_nettype wire

// *** pkg/aud_err_if.sv ***
`default_nettype none
// ****************************************************************
// audio fifo error events, clear and sticky status
// ****************************************************************
interface aud_err_if;
   logic overrun_evt;
   logic underrun_evt;
   logic clear;
   logic overrun_sts;
   logic underrun_sts;
   modport owner (input overrun_evt, input underrun_evt, input clear,
                  output overrun_sts, output underrun_sts);
   modport user  (output overrun_evt, output underrun_evt, output clear,
                  input overrun_sts, input underrun_sts);
endinterface
`default_nettype wire

// *** pkg/cfg_pkg.sv ***
`default_nettype none
// ****************************************************************
// register map, field positions and reset values
// ****************************************************************
package cfg_pkg;
   // register addresses on the local control port
   localparam logic [7:0] ADDR_DP_CTL2   = 8'h28;
   localparam logic [7:0] ADDR_AUD_CTL   = 8'h2B;
   localparam logic [7:0] ADDR_PCLK_TEST = 8'h2E;
   localparam logic [7:0] ADDR_RX_CTL    = 8'h34;

   // datapath_control_two fields
   localparam int unsigned DP_HOLD    = 7;
   localparam int unsigned DP_VID_DIS = 5;
   localparam int unsigned DP_DUAL    = 4;
   localparam int unsigned DP_ALT_AUD = 3;
   localparam int unsigned DP_AUD_DIS = 2;
   localparam int unsigned DP_SYNC    = 1;
   localparam int unsigned DP_SURR    = 0;
   localparam logic [7:0]  DP_SW_MASK   = 8'hEF; // all but link width
   localparam logic [7:0]  DP_FC_MASK   = 8'h2F; // fields loaded unless held
   localparam logic [7:0]  DP_FC_ALWAYS = 8'h10; // link width, always loaded
   localparam logic [7:0]  DP_RST       = 8'h00;

   // audio_serial_control fields
   localparam int unsigned AUD_OVR     = 3;
   localparam int unsigned AUD_UND     = 2;
   localparam int unsigned AUD_ERR_RST = 1;
   localparam int unsigned AUD_EDGE    = 0;
   localparam logic [7:0]  AUD_SW_MASK = 8'hF3;
   localparam logic [7:0]  AUD_RST     = 8'h00;

   // pixel_clock_test_mode fields
   localparam int unsigned PCLK_EXT = 7;
   localparam logic [7:0]  PCLK_RST = 8'h00;

   // receive lane mode field
   localparam int unsigned RX_MODE_LO = 3;
   localparam int unsigned RX_MODE_W  = 2;
   typedef enum logic [1:0] {LANE_AUTO, LANE_DUAL, LANE_PRIMARY, LANE_SECONDARY} lane_mode_t;
   localparam lane_mode_t  RX_MODE_RST = LANE_AUTO;
   localparam logic [1:0]  LANES_BOTH  = 2'h3;
   localparam logic [1:0]  LANES_PRI   = 2'h1;
   localparam logic [1:0]  LANES_SEC   = 2'h2;

   // audio lanes and general pins
   localparam int unsigned AUD_LANES        = 4;
   localparam logic [3:0]  LANE_MASK_ALL    = 4'hF;
   localparam logic [3:0]  LANE_MASK_STEREO = 4'h1;
   localparam int unsigned GPIO_PINS        = 2;
   localparam int unsigned PIN_ZERO         = 0;
   localparam int unsigned PIN_ONE          = 1;
endpackage
`default_nettype wire

// *** rtl/aud_err_sticky.sv ***
`default_nettype none
// ****************************************************************
// sticky audio fifo overrun / underrun flags
// ****************************************************************
module aud_err_sticky (
   // clock, reset, enable
   input  wire logic  clk,
   input  wire logic  rst_b,
   input  wire logic  ce,
   // events in, status out
   aud_err_if.owner   err
);
   logic ovr_r, und_r;
   logic ovr_nxt, und_nxt;

   // clear level dominates so a held clear masks new errors
   always_comb begin
      ovr_nxt = ovr_r | err.overrun_evt;
      und_nxt = und_r | err.underrun_evt;
      if (err.clear) begin
         ovr_nxt = '0;
         und_nxt = '0;
      end
   end

   // status flops, zero out of reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ovr_r <= '0;
         und_r <= '0;
      end else if (ce) begin
         ovr_r <= ovr_nxt;
         und_r <= und_nxt;
      end
   end

   assign err.overrun_sts  = ovr_r;
   assign err.underrun_sts = und_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   clear_wins_a: assert property (ce && err.clear |=> !ovr_r && !und_r)
      else $error("fifo error flags not cleared");
   ovr_sticky_a: assert property (ce && !err.clear && (ovr_r || err.overrun_evt) |=> ovr_r)
      else $error("overrun flag lost");
   und_sticky_a: assert property (ce && !err.clear && (und_r || err.underrun_evt) |=> und_r)
      else $error("underrun flag lost");
endmodule
`default_nettype wire

// *** rtl/deser_datapath_audio_cfg.sv ***
// Behaviour
// - without hold, forward-channel config loads the datapath control fields
// - with hold set, forward channel loads only the link width; local writes stay
// - video-disabled bit reads 1 when no active video arrives
// - control channel and general pins keep working while video is disabled
// - hold set freezes the video-disabled bit against forward traffic
// - link-width bit is read-only, always from forward channel
// - alternate audio puts word clock on pin one, data on pin zero
// - audio-disable bit silences the serial audio output
// - sync-present bit marks sync and enable carried with pixel data
// - surround bit enables the extra serial audio data lanes
// - audio fifo overrun shows in a read-only bit resetting to 0
// - audio fifo underrun shows in a separate read-only bit resetting to 0
// - writing 1 to error reset clears overrun and underrun flags
// - edge select: 1 strobes audio data on rising, 0 on falling edge
// - external pixel clock bit selects the test clock input pin
// - lane mode: auto, forced two-lane, forced primary, forced secondary
`default_nettype none
module deser_datapath_audio_cfg (
   // clock, reset, enable
   input  wire logic                                clk,
   input  wire logic                                rst_b,
   input  wire logic                                ce,
   // local register port
   input  wire logic [7:0]                          reg_addr,
   input  wire logic [7:0]                          reg_wdata,
   input  wire logic                                reg_wr,
   input  wire logic                                reg_rd,
   output logic [7:0]                               reg_rdata,
   output logic                                     reg_rvalid,
   // forward channel configuration
   input  wire logic                                fc_cfg_valid,
   input  wire logic [7:0]                          fc_cfg,
   // audio path from the internal fifo
   input  wire logic                                aud_bclk,
   input  wire logic                                aud_wclk,
   input  wire logic [cfg_pkg::AUD_LANES-1:0]       aud_data,
   input  wire logic                                aud_overrun_evt,
   input  wire logic                                aud_underrun_evt,
   // serial audio output
   output logic                                     i2s_bclk_o,
   output logic                                     i2s_wclk_o,
   output logic [cfg_pkg::AUD_LANES-1:0]            i2s_data_o,
   // general pin functions
   input  wire logic [cfg_pkg::GPIO_PINS-1:0]       gpio_func_out,
   input  wire logic [cfg_pkg::GPIO_PINS-1:0]       gpio_func_oe,
   output logic [cfg_pkg::GPIO_PINS-1:0]            gpio_func_in,
   // general pin pads
   input  wire logic                                general_pin_zero_i,
   output logic                                     general_pin_zero_o,
   output logic                                     general_pin_zero_oe,
   input  wire logic                                general_pin_one_i,
   output logic                                     general_pin_one_o,
   output logic                                     general_pin_one_oe,
   // datapath status and control
   output logic                                     video_disabled_o,
   output logic                                     dual_link_o,
   output logic                                     sync_signals_present_o,
   output logic                                     hold_local_config_o,
   output logic                                     ctl_channel_en_o,
   output logic                                     aud_edge_rising_o,
   output logic                                     pclk_from_test_clock_o,
   output cfg_pkg::lane_mode_t                      receive_lane_mode_o,
   output logic [1:0]                               rx_lane_en_o
);

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_q1_r, rst_q_b;

   // async assert, two-flop release so the core leaves reset cleanly
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_q1_r <= '0;
         rst_q_b  <= '0;
      end else begin
         rst_q1_r <= '1;
         rst_q_b  <= rst_q1_r;
      end
   end

   // ****************************************************************
   // register state
   // ****************************************************************
   logic [7:0]          dp_r, dp_nxt;
   logic [7:0]          aud_r, aud_nxt;
   logic [7:0]          pclk_r, pclk_nxt;
   cfg_pkg::lane_mode_t rx_mode_r, rx_mode_nxt;
   logic [7:0]          rdata_r, rdata_nxt;
   logic                rvalid_r;
   logic [7:0]          aud_rd;
   logic                wr_dp, wr_aud, wr_pclk, wr_rx;

   aud_err_if err ();

   assign wr_dp   = reg_wr && (reg_addr == cfg_pkg::ADDR_DP_CTL2);
   assign wr_aud  = reg_wr && (reg_addr == cfg_pkg::ADDR_AUD_CTL);
   assign wr_pclk = reg_wr && (reg_addr == cfg_pkg::ADDR_PCLK_TEST);
   assign wr_rx   = reg_wr && (reg_addr == cfg_pkg::ADDR_RX_CTL);

   // forward loading beats a local write in the same cycle unless held
   always_comb begin
      dp_nxt = dp_r;
      if (wr_dp) begin
         dp_nxt = (dp_r & ~cfg_pkg::DP_SW_MASK) | (reg_wdata & cfg_pkg::DP_SW_MASK);
      end
      if (fc_cfg_valid && !dp_r[cfg_pkg::DP_HOLD]) begin
         dp_nxt = (dp_nxt & ~cfg_pkg::DP_FC_MASK) | (fc_cfg & cfg_pkg::DP_FC_MASK);
      end
      if (fc_cfg_valid) begin
         dp_nxt = (dp_nxt & ~cfg_pkg::DP_FC_ALWAYS) | (fc_cfg & cfg_pkg::DP_FC_ALWAYS);
      end
   end

   // audio control: status bits live in the sticky module, not here
   always_comb begin
      aud_nxt = aud_r;
      if (wr_aud) begin
         aud_nxt = reg_wdata & cfg_pkg::AUD_SW_MASK;
      end
      pclk_nxt = wr_pclk ? reg_wdata : pclk_r;
      rx_mode_nxt = rx_mode_r;
      if (wr_rx) begin
         rx_mode_nxt = cfg_pkg::lane_mode_t'(reg_wdata[cfg_pkg::RX_MODE_LO +: cfg_pkg::RX_MODE_W]);
      end
   end

   // read mux; unmapped addresses answer zero
   always_comb begin
      aud_rd = aud_r;
      aud_rd[cfg_pkg::AUD_OVR] = err.overrun_sts;
      aud_rd[cfg_pkg::AUD_UND] = err.underrun_sts;
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            cfg_pkg::ADDR_DP_CTL2:   rdata_nxt = dp_r;
            cfg_pkg::ADDR_AUD_CTL:   rdata_nxt = aud_rd;
            cfg_pkg::ADDR_PCLK_TEST: rdata_nxt = pclk_r;
            cfg_pkg::ADDR_RX_CTL:    rdata_nxt = 8'(8'(rx_mode_r) << cfg_pkg::RX_MODE_LO);
            default:                 rdata_nxt = '0;
         endcase
      end
   end

   // register flops
   always_ff @(posedge clk or negedge rst_q_b) begin
      if (!rst_q_b) begin
         dp_r      <= cfg_pkg::DP_RST;
         aud_r     <= cfg_pkg::AUD_RST;
         pclk_r    <= cfg_pkg::PCLK_RST;
         rx_mode_r <= cfg_pkg::RX_MODE_RST;
         rdata_r   <= '0;
         rvalid_r  <= '0;
      end else if (ce) begin
         dp_r      <= dp_nxt;
         aud_r     <= aud_nxt;
         pclk_r    <= pclk_nxt;
         rx_mode_r <= rx_mode_nxt;
         rdata_r   <= rdata_nxt;
         rvalid_r  <= reg_rd;
      end
   end

   // ****************************************************************
   // audio fifo error flags
   // ****************************************************************
   // clear follows the bit level, so a bit left at 1 keeps flags at 0
   assign err.overrun_evt  = aud_overrun_evt;
   assign err.underrun_evt = aud_underrun_evt;
   assign err.clear        = aud_r[cfg_pkg::AUD_ERR_RST];

   aud_err_sticky u_err (
      .clk   (clk),
      .rst_b (rst_q_b),
      .ce    (ce),
      .err   (err)
   );

   // ****************************************************************
   // serial audio output
   // ****************************************************************
   logic                          bclk_prev_r, launch;
   logic                          bclk_o_r, bclk_o_nxt;
   logic                          wclk_r, wclk_nxt;
   logic [cfg_pkg::AUD_LANES-1:0] data_r, data_nxt, lane_mask;

   // data moves on the edge opposite the strobe edge, half a bit early
   always_comb begin
      launch = aud_r[cfg_pkg::AUD_EDGE] ? (bclk_prev_r && !aud_bclk)
                                        : (!bclk_prev_r && aud_bclk);
      lane_mask = dp_r[cfg_pkg::DP_SURR] ? cfg_pkg::LANE_MASK_ALL
                                         : cfg_pkg::LANE_MASK_STEREO;
      data_nxt   = (launch ? aud_data : data_r) & lane_mask;
      wclk_nxt   = launch ? aud_wclk : wclk_r;
      bclk_o_nxt = aud_bclk;
      if (dp_r[cfg_pkg::DP_AUD_DIS]) begin
         data_nxt   = '0;
         wclk_nxt   = '0;
         bclk_o_nxt = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_q_b) begin
      if (!rst_q_b) begin
         bclk_prev_r <= '0;
         bclk_o_r    <= '0;
         wclk_r      <= '0;
         data_r      <= '0;
      end else if (ce) begin
         bclk_prev_r <= aud_bclk;
         bclk_o_r    <= bclk_o_nxt;
         wclk_r      <= wclk_nxt;
         data_r      <= data_nxt;
      end
   end

   // ****************************************************************
   // general pins and lane selection
   // ****************************************************************
   logic [cfg_pkg::GPIO_PINS-1:0] pin_o_r, pin_o_nxt, pin_oe_r, pin_oe_nxt;
   logic [1:0]                    lane_en_r, lane_en_nxt;

   // pins follow the gpio logic whatever the video state; audio takes over
   always_comb begin
      pin_o_nxt  = gpio_func_out;
      pin_oe_nxt = gpio_func_oe;
      if (dp_r[cfg_pkg::DP_ALT_AUD]) begin
         pin_o_nxt[cfg_pkg::PIN_ONE]  = wclk_r;
         pin_o_nxt[cfg_pkg::PIN_ZERO] = data_r[0];
         pin_oe_nxt                   = '1;
      end
   end

   // auto mode trusts the link width reported by the serializer
   always_comb begin
      case (rx_mode_r)
         cfg_pkg::LANE_AUTO:      lane_en_nxt = dp_r[cfg_pkg::DP_DUAL] ? cfg_pkg::LANES_BOTH
                                                                       : cfg_pkg::LANES_PRI;
         cfg_pkg::LANE_DUAL:      lane_en_nxt = cfg_pkg::LANES_BOTH;
         cfg_pkg::LANE_PRIMARY:   lane_en_nxt = cfg_pkg::LANES_PRI;
         cfg_pkg::LANE_SECONDARY: lane_en_nxt = cfg_pkg::LANES_SEC;
         default:                 lane_en_nxt = cfg_pkg::LANES_PRI;
      endcase
   end

   always_ff @(posedge clk or negedge rst_q_b) begin
      if (!rst_q_b) begin
         pin_o_r   <= '0;
         pin_oe_r  <= '0;
         lane_en_r <= cfg_pkg::LANES_PRI;
      end else if (ce) begin
         pin_o_r   <= pin_o_nxt;
         pin_oe_r  <= pin_oe_nxt;
         lane_en_r <= lane_en_nxt;
      end
   end

   pin_sync #(
      .WIDTH (cfg_pkg::GPIO_PINS)
   ) u_pin_sync (
      .clk   (clk),
      .rst_b (rst_q_b),
      .ce    (ce),
      .d     ({general_pin_one_i, general_pin_zero_i}),
      .q     (gpio_func_in)
   );

   // ****************************************************************
   // outputs, all taken from flops
   // ****************************************************************
   assign reg_rdata              = rdata_r;
   assign reg_rvalid             = rvalid_r;
   assign i2s_bclk_o             = bclk_o_r;
   assign i2s_wclk_o             = wclk_r;
   assign i2s_data_o             = data_r;
   assign general_pin_zero_o     = pin_o_r[cfg_pkg::PIN_ZERO];
   assign general_pin_zero_oe    = pin_oe_r[cfg_pkg::PIN_ZERO];
   assign general_pin_one_o      = pin_o_r[cfg_pkg::PIN_ONE];
   assign general_pin_one_oe     = pin_oe_r[cfg_pkg::PIN_ONE];
   assign video_disabled_o       = dp_r[cfg_pkg::DP_VID_DIS];
   assign dual_link_o            = dp_r[cfg_pkg::DP_DUAL];
   assign sync_signals_present_o = dp_r[cfg_pkg::DP_SYNC];
   assign hold_local_config_o    = dp_r[cfg_pkg::DP_HOLD];
   assign ctl_channel_en_o       = rst_q_b;
   assign aud_edge_rising_o      = aud_r[cfg_pkg::AUD_EDGE];
   assign pclk_from_test_clock_o = pclk_r[cfg_pkg::PCLK_EXT];
   assign receive_lane_mode_o    = rx_mode_r;
   assign rx_lane_en_o           = lane_en_r;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_q_b);

   sequence s_fc_load;
      ce && fc_cfg_valid && !dp_r[cfg_pkg::DP_HOLD];
   endsequence
   sequence s_rise_launch;
      ce && aud_r[cfg_pkg::AUD_EDGE] && bclk_prev_r && !aud_bclk && !dp_r[cfg_pkg::DP_AUD_DIS];
   endsequence

   fc_load_a: assert property (s_fc_load |=> (dp_r & cfg_pkg::DP_FC_MASK) ==
                                             $past(fc_cfg & cfg_pkg::DP_FC_MASK))
      else $error("forward config not loaded");
   vid_dis_a: assert property (s_fc_load |=> video_disabled_o == $past(fc_cfg[cfg_pkg::DP_VID_DIS]))
      else $error("video disabled status wrong");
   hold_keep_a: assert property (ce && dp_r[cfg_pkg::DP_HOLD] && !wr_dp |=>
                                 (dp_r & ~cfg_pkg::DP_FC_ALWAYS) == $past(dp_r & ~cfg_pkg::DP_FC_ALWAYS))
      else $error("held config changed");
   vid_hold_a: assert property (ce && dp_r[cfg_pkg::DP_HOLD] && !wr_dp ##1 ce && !wr_dp
                                |=> $stable(video_disabled_o))
      else $error("video disabled moved while held");
   dual_ro_a: assert property (ce && wr_dp && !fc_cfg_valid |=> $stable(dual_link_o))
      else $error("link width took a local write");
   alt_pins_a: assert property (ce && dp_r[cfg_pkg::DP_ALT_AUD] |=> general_pin_one_oe &&
                                general_pin_zero_oe && general_pin_one_o == $past(wclk_r))
      else $error("alternate audio pins wrong");
   gpio_pass_a: assert property (ce && !dp_r[cfg_pkg::DP_ALT_AUD] |=>
                                 general_pin_zero_o == $past(gpio_func_out[cfg_pkg::PIN_ZERO]))
      else $error("general pin not passed through");
   aud_off_a: assert property (ce && dp_r[cfg_pkg::DP_AUD_DIS] |=> i2s_data_o == '0 && !i2s_wclk_o)
      else $error("audio not silenced");
   surr_off_a: assert property (ce && !dp_r[cfg_pkg::DP_SURR] |=>
                                i2s_data_o[cfg_pkg::AUD_LANES-1:1] == '0)
      else $error("surround lanes active");
   edge_rise_a: assert property (s_rise_launch |=> i2s_data_o[0] == $past(aud_data[0]))
      else $error("audio data not launched");
   lane_fix_a: assert property (ce && rx_mode_r == cfg_pkg::LANE_SECONDARY |=>
                                rx_lane_en_o == cfg_pkg::LANES_SEC)
      else $error("forced secondary lane wrong");
endmodule
`default_nettype wire

// *** rtl/pin_sync.sv ***
`default_nettype none
// ****************************************************************
// three-stage pin synchroniser with agreement filter
// ****************************************************************
module pin_sync #(
   parameter int unsigned WIDTH = 2
) (
   // clock, reset, enable
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             ce,
   // pad side and synchronised side
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic s1_r, s2_r, s3_r, q_r;
         logic q_nxt;
         // stage one feeds stage two only; output moves once two and three agree
         always_comb begin
            q_nxt = q_r;
            if (s2_r == s3_r) begin
               q_nxt = s3_r;
            end
         end
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               s1_r <= '0;
               s2_r <= '0;
               s3_r <= '0;
               q_r  <= '0;
            end else if (ce) begin
               s1_r <= d[i];
               s2_r <= s1_r;
               s3_r <= s2_r;
               q_r  <= q_nxt;
            end
         end
         assign q[i] = q_r;
      end
   endgenerate
endmodule
`default_nettype wire
